// file: hw/lnerr_pkg.sv
// shared constants and types for the lin fault detection block
package lnerr_pkg;

    // indirect register indices
    localparam logic [7:0] IDX_CTRL = 8'h08;
    localparam logic [7:0] IDX_STAT = 8'h09;
    localparam logic [7:0] IDX_FAULT = 8'h0a;

    // fault flag bit positions
    localparam int FLT_SYNC = 4;
    localparam int FLT_PAR = 3;
    localparam int FLT_NO_RESPONSE_FAULT = 2;
    localparam int FLT_SUM = 1;
    localparam int FLT_BIT = 0;
    localparam int FLT_W = 5;

    // control bit positions
    localparam int CB_STOP = 7;
    localparam int CB_DACK = 4;
    localparam int CB_CLR = 2;
    localparam int CB_WAKE = 1;
    localparam int CB_START = 0;

    // status bit positions
    localparam int SB_ERR = 2;

    // values after reset
    localparam logic [7:0] INDEX_RESET = 8'h00;
    localparam logic [FLT_W-1:0] FAULT_RESET = 5'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // timing
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned WAKE_NO_RESPONSE_FAULT_MS = 150;
    localparam int unsigned WAKE_NO_RESPONSE_FAULT_CYC = WAKE_NO_RESPONSE_FAULT_MS * (CLK_HZ / 1000);
    localparam int unsigned FRAME_MAX_US = 1000;
    localparam int unsigned FRAME_MAX_CYC = FRAME_MAX_US * (CLK_HZ / 1_000_000);
    localparam int TMR_W = 24;
    localparam logic [TMR_W-1:0] TMR_RESET = 24'h000000;

    typedef enum logic [0:0] {
        TMR_IDLE = 1'b0,
        TMR_RUN = 1'b1
    } lnerr_tmr_e;

    typedef struct packed {
        lnerr_tmr_e mode;
        logic [TMR_W-1:0] cnt;
        logic expire;
    } lnerr_tmr_s;

    typedef struct packed {
        logic par_fault;
        logic sum_fault;
    } lnerr_chk_s;

    typedef struct packed {
        logic [7:0] index;
        logic [FLT_W-1:0] fault;
        logic err;
        logic data_ack;
        logic stop;
        logic await_ack;
        logic [7:0] rdata;
        logic irq;
        logic abort;
        logic start;
        logic wake_tx;
    } lnerr_state_s;

endpackage

// file: hw/lnerr_timer.sv
// restartable timeout counter with a one-cycle expiry pulse
`timescale 1ns/1ps
`default_nettype none
module lnerr_timer #(
    parameter int unsigned LIMIT = 16
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // control
    input wire logic start_in,
    input wire logic stop_in,
    // result
    output logic expire_out
);
    localparam logic [lnerr_pkg::TMR_W-1:0] LAST = (lnerr_pkg::TMR_W)'(LIMIT - 1);

    lnerr_pkg::lnerr_tmr_s state;
    lnerr_pkg::lnerr_tmr_s next_state;

    always_comb begin
        next_state = state;
        next_state.expire = 1'b0;
        case (state.mode)
            lnerr_pkg::TMR_IDLE: begin
                if (start_in) begin
                    next_state.mode = lnerr_pkg::TMR_RUN;
                    next_state.cnt = lnerr_pkg::TMR_RESET;
                end
            end
            lnerr_pkg::TMR_RUN: begin
                if (stop_in) begin
                    next_state.mode = lnerr_pkg::TMR_IDLE;
                end else if (start_in) begin
                    next_state.cnt = lnerr_pkg::TMR_RESET;
                end else if (state.cnt == LAST) begin
                    next_state.mode = lnerr_pkg::TMR_IDLE;
                    next_state.expire = 1'b1;
                end else begin
                    next_state.cnt = state.cnt + 1'b1;
                end
            end
            default: begin
                next_state.mode = lnerr_pkg::TMR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state.mode <= lnerr_pkg::TMR_IDLE;
            state.cnt <= lnerr_pkg::TMR_RESET;
            state.expire <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign expire_out = state.expire;
endmodule
`default_nettype wire

// file: hw/lnerr_field_check.sv
// identifier parity and checksum comparison
`timescale 1ns/1ps
`default_nettype none
module lnerr_field_check (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // identifier field
    input wire logic pid_valid_in,
    input wire logic [7:0] pid_in,
    // checksum field
    input wire logic sum_valid_in,
    input wire logic [7:0] sum_rx_in,
    input wire logic [7:0] sum_calc_in,
    // results, one-cycle pulses
    output logic par_fault_out,
    output logic sum_fault_out
);
    lnerr_pkg::lnerr_chk_s state;
    lnerr_pkg::lnerr_chk_s next_state;
    logic p0;
    logic p1;

    always_comb begin
        // two parity bits sit above the six identifier bits
        p0 = pid_in[0] ^ pid_in[1] ^ pid_in[2] ^ pid_in[4];
        p1 = ~(pid_in[1] ^ pid_in[3] ^ pid_in[4] ^ pid_in[5]);
        next_state.par_fault = pid_valid_in && ({p1, p0} != pid_in[7:6]);
        next_state.sum_fault = sum_valid_in && (sum_rx_in != sum_calc_in);
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign par_fault_out = state.par_fault;
    assign sum_fault_out = state.sum_fault;
endmodule
`default_nettype wire

// file: hw/lnerr_top.sv
// lin fault detection, fault flags and recovery gating
//
// Behaviour
// - any detected fault raises an interrupt and abandons the current frame.
// - a one on the fault clear command clears all fault flags and the error flag.
// - master frame start and wake-up sending are refused while the error flag is set.
// - in slave mode, a sync field outside tolerance sets fault bit 4.
// - in slave mode, an identifier parity error sets fault bit 3.
// - a missing slave response or missing bus data sets fault bit 2.
// - a frame exceeding the maximum frame length also sets the timeout fault.
// - without data acknowledge or stop before the first data byte ends, timeout is set.
// - a received checksum that differs from the computed one sets fault bit 1.
// - a readback bit differing from the driven bit sets fault bit 0.
// - the fault flags are read-only, reset to zero, with bits 7 to 5 reading zero.
// - an unanswered slave wake-up sets the error flag and timeout fault and interrupts.
// - internal registers are reached through an index register and a data register.
`timescale 1ns/1ps
`default_nettype none
module lnerr_top #(
    parameter int unsigned WAKE_NO_RESPONSE_FAULT_CYCLES = lnerr_pkg::WAKE_NO_RESPONSE_FAULT_CYC,
    parameter int unsigned FRAME_MAX_CYCLES = lnerr_pkg::FRAME_MAX_CYC
) (
    // clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic SRST_IN,
    // indirect register port
    input wire logic REG_SEL_DATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [7:0] REG_WDATA_IN,
    output logic [7:0] REG_RDATA_OUT,
    // mode
    input wire logic SLAVE_MODE_IN,
    // frame engine events
    input wire logic FRAME_BEGIN_IN,
    input wire logic FRAME_END_IN,
    input wire logic SYNC_TOL_FAIL_IN,
    input wire logic PID_VALID_IN,
    input wire logic [7:0] PID_IN,
    input wire logic ID_DONE_IN,
    input wire logic FIRST_BYTE_DONE_IN,
    input wire logic NO_RESPONSE_IN,
    input wire logic SUM_VALID_IN,
    input wire logic [7:0] SUM_RX_IN,
    input wire logic [7:0] SUM_CALC_IN,
    // bit readback
    input wire logic BIT_SAMPLE_IN,
    input wire logic TX_BIT_IN,
    input wire logic RX_BIT_IN,
    // wake-up handshake
    input wire logic WAKE_SENT_IN,
    input wire logic BUS_ACTIVITY_IN,
    // results to the frame engine and core
    output logic IRQ_OUT,
    output logic FRAME_ABORT_OUT,
    output logic FRAME_START_OUT,
    output logic WAKE_TX_OUT,
    output logic DATA_ACK_OUT,
    output logic STOP_OUT,
    output logic ERROR_OUT
);
    lnerr_pkg::lnerr_state_s state;
    lnerr_pkg::lnerr_state_s next_state;

    logic par_fault;
    logic sum_fault;
    logic frame_expire;
    logic wake_expire;
    logic wake_start;
    logic frame_stop;
    logic data_wr;
    logic data_rd;
    logic clr_cmd;
    logic [lnerr_pkg::FLT_W-1:0] evt;
    logic any_evt;
    logic [7:0] rd_mux;

    // parity and checksum compare
    lnerr_field_check u_check (
        .clk_in(CLK_SYS_IN),
        .srst_in(SRST_IN),
        .pid_valid_in(PID_VALID_IN),
        .pid_in(PID_IN),
        .sum_valid_in(SUM_VALID_IN),
        .sum_rx_in(SUM_RX_IN),
        .sum_calc_in(SUM_CALC_IN),
        .par_fault_out(par_fault),
        .sum_fault_out(sum_fault)
    );

    // frame length watchdog, stopped by the frame end or by any abort
    assign frame_stop = FRAME_END_IN | state.abort;

    lnerr_timer #(
        .LIMIT(FRAME_MAX_CYCLES)
    ) u_frame_tmr (
        .clk_in(CLK_SYS_IN),
        .srst_in(SRST_IN),
        .start_in(FRAME_BEGIN_IN),
        .stop_in(frame_stop),
        .expire_out(frame_expire)
    );

    // only a slave waits for the master to answer its wake-up
    assign wake_start = WAKE_SENT_IN & SLAVE_MODE_IN;

    lnerr_timer #(
        .LIMIT(WAKE_NO_RESPONSE_FAULT_CYCLES)
    ) u_wake_tmr (
        .clk_in(CLK_SYS_IN),
        .srst_in(SRST_IN),
        .start_in(wake_start),
        .stop_in(BUS_ACTIVITY_IN),
        .expire_out(wake_expire)
    );

    assign data_wr = REG_WR_IN & REG_SEL_DATA_IN;
    assign data_rd = REG_RD_IN & REG_SEL_DATA_IN;
    assign clr_cmd = data_wr && (state.index == lnerr_pkg::IDX_CTRL)
        && REG_WDATA_IN[lnerr_pkg::CB_CLR];

    // fault events of this cycle
    always_comb begin
        evt = '0;
        evt[lnerr_pkg::FLT_SYNC] = SLAVE_MODE_IN & SYNC_TOL_FAIL_IN;
        evt[lnerr_pkg::FLT_PAR] = SLAVE_MODE_IN & par_fault;
        evt[lnerr_pkg::FLT_NO_RESPONSE_FAULT] = NO_RESPONSE_IN
            | frame_expire
            | wake_expire
            | (FIRST_BYTE_DONE_IN & state.await_ack
               & ~state.data_ack & ~state.stop);
        evt[lnerr_pkg::FLT_SUM] = sum_fault;
        evt[lnerr_pkg::FLT_BIT] = BIT_SAMPLE_IN & (TX_BIT_IN ^ RX_BIT_IN);
        any_evt = |evt;
    end

    // read path of the data register
    always_comb begin
        rd_mux = 8'h00;
        case (state.index)
            lnerr_pkg::IDX_CTRL: begin
                rd_mux[lnerr_pkg::CB_STOP] = state.stop;
                rd_mux[lnerr_pkg::CB_DACK] = state.data_ack;
            end
            lnerr_pkg::IDX_STAT: begin
                rd_mux[lnerr_pkg::SB_ERR] = state.err;
            end
            lnerr_pkg::IDX_FAULT: begin
                // upper three bits stay zero
                rd_mux = {3'h0, state.fault};
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    always_comb begin
        next_state = state;
        next_state.irq = 1'b0;
        next_state.abort = 1'b0;
        next_state.start = 1'b0;
        next_state.wake_tx = 1'b0;

        // index register written and read directly
        if (REG_WR_IN && !REG_SEL_DATA_IN) begin
            next_state.index = REG_WDATA_IN;
        end
        if (REG_RD_IN) begin
            next_state.rdata = REG_SEL_DATA_IN ? rd_mux : state.index;
        end

        // a new identifier opens a fresh acknowledge window
        if (ID_DONE_IN) begin
            next_state.await_ack = 1'b1;
            next_state.data_ack = 1'b0;
            next_state.stop = 1'b0;
        end
        if (FIRST_BYTE_DONE_IN) begin
            next_state.await_ack = 1'b0;
        end

        // control writes; fault flags ignore writes entirely
        if (data_wr && (state.index == lnerr_pkg::IDX_CTRL)) begin
            if (REG_WDATA_IN[lnerr_pkg::CB_DACK]) begin
                next_state.data_ack = 1'b1;
            end
            if (REG_WDATA_IN[lnerr_pkg::CB_STOP]) begin
                next_state.stop = 1'b1;
            end
            // uses the registered flag, so a fault of this cycle does not race
            if (REG_WDATA_IN[lnerr_pkg::CB_START] && !SLAVE_MODE_IN && !state.err) begin
                next_state.start = 1'b1;
            end
            if (REG_WDATA_IN[lnerr_pkg::CB_WAKE] && !state.err) begin
                next_state.wake_tx = 1'b1;
            end
        end

        // clear first, then new events, so a fault in the clear cycle survives
        if (clr_cmd) begin
            next_state.fault = lnerr_pkg::FAULT_RESET;
            next_state.err = 1'b0;
        end
        next_state.fault = next_state.fault | evt;
        if (any_evt) begin
            next_state.err = 1'b1;
            next_state.irq = 1'b1;
            next_state.abort = 1'b1;
            next_state.await_ack = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (SRST_IN) begin
            state.index <= lnerr_pkg::INDEX_RESET;
            state.fault <= lnerr_pkg::FAULT_RESET;
            state.err <= 1'b0;
            state.data_ack <= 1'b0;
            state.stop <= 1'b0;
            state.await_ack <= 1'b0;
            state.rdata <= lnerr_pkg::RDATA_RESET;
            state.irq <= 1'b0;
            state.abort <= 1'b0;
            state.start <= 1'b0;
            state.wake_tx <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign REG_RDATA_OUT = state.rdata;
    assign IRQ_OUT = state.irq;
    assign FRAME_ABORT_OUT = state.abort;
    assign FRAME_START_OUT = state.start;
    assign WAKE_TX_OUT = state.wake_tx;
    assign DATA_ACK_OUT = state.data_ack;
    assign STOP_OUT = state.stop;
    assign ERROR_OUT = state.err;
endmodule
`default_nettype wire

// file: test/lnerr_props.sv
// port-level assertions for the lin fault block
`timescale 1ns/1ps
`default_nettype none
module lnerr_props (
    // clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic SRST_IN,
    // register port
    input wire logic REG_SEL_DATA_IN,
    input wire logic REG_WR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    // events
    input wire logic SLAVE_MODE_IN,
    input wire logic SYNC_TOL_FAIL_IN,
    input wire logic SUM_VALID_IN,
    input wire logic [7:0] SUM_RX_IN,
    input wire logic [7:0] SUM_CALC_IN,
    input wire logic BIT_SAMPLE_IN,
    input wire logic TX_BIT_IN,
    input wire logic RX_BIT_IN,
    // results
    input wire logic IRQ_OUT,
    input wire logic FRAME_ABORT_OUT,
    input wire logic FRAME_START_OUT,
    input wire logic WAKE_TX_OUT,
    input wire logic ERROR_OUT
);
    logic [7:0] idx;
    logic ctrl_wr;
    logic clr;
    logic start_ok;
    logic wake_ok;
    assign ctrl_wr = REG_WR_IN && REG_SEL_DATA_IN && idx == lnerr_pkg::IDX_CTRL;
    assign clr = ctrl_wr && REG_WDATA_IN[2];
    assign start_ok = ctrl_wr && REG_WDATA_IN[0] && !ERROR_OUT && !SLAVE_MODE_IN;
    assign wake_ok = ctrl_wr && REG_WDATA_IN[1] && !ERROR_OUT;
    // shadow of the index register, so control writes can be recognised
    always_ff @(posedge CLK_SYS_IN) begin
        if (SRST_IN) begin
            idx <= 8'h00;
        end else if (REG_WR_IN && !REG_SEL_DATA_IN) begin
            idx <= REG_WDATA_IN;
        end
    end
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (SRST_IN);
    property p_irq_abort;
        IRQ_OUT == FRAME_ABORT_OUT;
    endproperty
    a_irq_abort: assert property (p_irq_abort) else $error("irq and abort differ");
    property p_readback;
        BIT_SAMPLE_IN && (TX_BIT_IN != RX_BIT_IN) |=> IRQ_OUT && ERROR_OUT;
    endproperty
    a_readback: assert property (p_readback) else $error("readback fault missed");
    property p_sum;
        SUM_VALID_IN && (SUM_RX_IN != SUM_CALC_IN) |-> ##2 ERROR_OUT;
    endproperty
    a_sum: assert property (p_sum) else $error("checksum fault missed");
    property p_sync;
        SYNC_TOL_FAIL_IN && SLAVE_MODE_IN |=> ERROR_OUT && IRQ_OUT;
    endproperty
    a_sync: assert property (p_sync) else $error("sync fault missed");
    property p_start;
        FRAME_START_OUT |-> $past(start_ok);
    endproperty
    a_start: assert property (p_start) else $error("start not allowed");
    property p_wake;
        WAKE_TX_OUT |-> $past(wake_ok);
    endproperty
    a_wake: assert property (p_wake) else $error("wake not allowed");
    property p_clear;
        clr |=> !ERROR_OUT || IRQ_OUT;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not clear");
    property p_hold;
        $fell(ERROR_OUT) |-> $past(clr);
    endproperty
    a_hold: assert property (p_hold) else $error("error dropped unasked");
    property p_rise;
        $rose(ERROR_OUT) |-> IRQ_OUT;
    endproperty
    a_rise: assert property (p_rise) else $error("fault without irq");
endmodule
bind lnerr_top lnerr_props lnerr_props_inst (.CLK_SYS_IN, .SRST_IN, .REG_SEL_DATA_IN,
    .REG_WR_IN, .REG_WDATA_IN, .SLAVE_MODE_IN, .SYNC_TOL_FAIL_IN, .SUM_VALID_IN, .SUM_RX_IN,
    .SUM_CALC_IN, .BIT_SAMPLE_IN, .TX_BIT_IN, .RX_BIT_IN, .IRQ_OUT, .FRAME_ABORT_OUT,
    .FRAME_START_OUT, .WAKE_TX_OUT, .ERROR_OUT);
`default_nettype wire

// file: test/lnerr_node_model.sv
// lin node as seen by a transmitter: echoes the driven bit or overrides it
`timescale 1ns/1ps
`default_nettype none
module lnerr_node_model (
    // transmitter side
    input wire logic tx_bit_in,
    // override from the bench
    input wire logic flip_in,
    // level read back from the wire
    output logic rx_bit_out
);
    // a dominant node elsewhere shows up as an inverted readback
    assign rx_bit_out = tx_bit_in ^ flip_in;
endmodule
`default_nettype wire

// file: test/tb_lnerr_top.sv
// self-checking bench for the lin fault block
`timescale 1ns/1ps
`default_nettype none
module tb_lnerr_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic sel = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0, slave = 1'b0, flip = 1'b0, tx = 1'b0;
    logic rx, irq, abort, start, wake, dack, stop, err;
    logic [7:0] wd = 8'h00, pid = 8'h00, srx = 8'h00, scalc = 8'h00, rdata;
    logic [10:0] ev = 11'h000;
    logic [7:0] exp_q[$];
    logic [7:0] exp_flt [14] = '{8'h10, 8'h00, 8'h08, 8'h00, 8'h04, 8'h04, 8'h00, 8'h04,
        8'h00, 8'h02, 8'h00, 8'h01, 8'h04, 8'h00};
    int n_fail = 0;
    int n_compared = 0;
    initial forever #5 clk = ~clk;
    lnerr_top #(.WAKE_NO_RESPONSE_FAULT_CYCLES(20), .FRAME_MAX_CYCLES(30)) lnerr_top_inst (
        .CLK_SYS_IN(clk), .SRST_IN(srst), .REG_SEL_DATA_IN(sel), .REG_WR_IN(wr),
        .REG_RD_IN(rd), .REG_WDATA_IN(wd), .REG_RDATA_OUT(rdata), .SLAVE_MODE_IN(slave),
        .FRAME_BEGIN_IN(ev[8]), .FRAME_END_IN(ev[9]), .SYNC_TOL_FAIL_IN(ev[0]),
        .PID_VALID_IN(ev[1]), .PID_IN(pid), .ID_DONE_IN(ev[2]), .FIRST_BYTE_DONE_IN(ev[3]),
        .NO_RESPONSE_IN(ev[4]), .SUM_VALID_IN(ev[5]), .SUM_RX_IN(srx), .SUM_CALC_IN(scalc),
        .BIT_SAMPLE_IN(ev[6]), .TX_BIT_IN(tx), .RX_BIT_IN(rx), .WAKE_SENT_IN(ev[7]),
        .BUS_ACTIVITY_IN(ev[10]), .IRQ_OUT(irq), .FRAME_ABORT_OUT(abort),
        .FRAME_START_OUT(start), .WAKE_TX_OUT(wake), .DATA_ACK_OUT(dack), .STOP_OUT(stop),
        .ERROR_OUT(err));
    lnerr_node_model lnerr_node_model_inst (.tx_bit_in(tx), .flip_in(flip), .rx_bit_out(rx));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expv);
        n_compared++;
        if (seen !== expv) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, expv, seen);
        end
    endtask
    task automatic print_verdict();
        if (n_fail == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sel <= 1'b0;
        wr <= 1'b1;
        wd <= a;
        @(posedge clk);
        sel <= 1'b1;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        sel <= 1'b0;
        wr <= 1'b1;
        wd <= a;
        @(posedge clk);
        wr <= 1'b0;
        sel <= 1'b1;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic pulse(input int b);
        @(posedge clk);
        ev[b] <= 1'b1;
        @(posedge clk);
        ev[b] <= 1'b0;
    endtask
    // read data lands one cycle after the read strobe
    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d) check("read data", rdata, exp_q.pop_front());
    end
    task automatic run_case(input int k);
        logic [7:0] r;
        r = 8'($urandom);
        slave <= (k != 1 && k != 3);
        case (k)
            0, 1: pulse(0);
            // second parity bit inverted on purpose
            2, 3: begin
                pid <= {^{r[1], r[3], r[4], r[5]}, ^{r[0], r[1], r[2], r[4]}, r[5:0]};
                pulse(1);
            end
            4: pulse(4);
            5, 6: begin
                pulse(8);
                if (k == 6) pulse(9);
                tick(35);
            end
            7: begin
                pulse(2);
                pulse(3);
            end
            8: begin
                pulse(2);
                reg_wr(lnerr_pkg::IDX_CTRL, 8'h90);
                pulse(3);
                check("data ack", {7'h00, dack}, 8'h01);
                check("stop", {7'h00, stop}, 8'h01);
            end
            9, 10: begin
                srx <= r;
                scalc <= (k == 9) ? r ^ (8'h01 | 8'($urandom)) : r;
                pulse(5);
            end
            11: begin
                tx <= r[0];
                flip <= 1'b1;
                pulse(6);
                flip <= 1'b0;
            end
            default: begin
                pulse(7);
                if (k == 13) pulse(10);
                tick(25);
            end
        endcase
        tick(3);
        reg_rd(lnerr_pkg::IDX_FAULT, exp_flt[k]);
        reg_rd(lnerr_pkg::IDX_STAT, (exp_flt[k] != 8'h00) ? 8'h04 : 8'h00);
        reg_wr(lnerr_pkg::IDX_CTRL, 8'h04);
        reg_rd(lnerr_pkg::IDX_FAULT, 8'h00);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    initial begin
        void'($urandom(88));
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        reg_wr(lnerr_pkg::IDX_FAULT, 8'hff);
        reg_rd(lnerr_pkg::IDX_FAULT, 8'h00);
        reg_rd(8'h33, 8'h00);
        tx <= 1'b1;
        flip <= 1'b1;
        pulse(6);
        // irq and abort stand only in the cycle right after the sampling edge
        #1;
        check("irq abort", {6'h00, irq, abort}, 8'h03);
        reg_wr(lnerr_pkg::IDX_CTRL, 8'h03);
        #1;
        check("start wake", {6'h00, start, wake}, 8'h00);
        pulse(0);
        tick(3);
        reg_rd(lnerr_pkg::IDX_FAULT, 8'h01);
        reg_wr(lnerr_pkg::IDX_CTRL, 8'h04);
        reg_wr(lnerr_pkg::IDX_CTRL, 8'h01);
        #1;
        check("start", {7'h00, start}, 8'h01);
        reg_wr(lnerr_pkg::IDX_CTRL, 8'h02);
        #1;
        check("wake", {7'h00, wake}, 8'h01);
        for (int k = 0; k < 14; k++) run_case(k);
        tick(4);
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
endmodule
`default_nettype wire
